// file: tb_ums_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ums_regs.svh"
module tb_ums_top;
    import ums_pkg::*;
    logic ref_clk_in, resetn_in, reg_wr_in, reg_rd_in, tx_bit_in, sample_tick_in, sck_gen_in;
    logic parity_err_in, char_good_in, iteration_clear_in, thr_write_in, thr_sync_in, lvl, n;
    logic [7:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, irq_status_in, lfsr_q, m, d;
    logic [3:0]  sck_hist;
    logic [7:0]  rst_ofs [5] = '{8'h08, 8'h0c, 8'h10, 8'h04, 8'h20};
    wire logic [31:0] reg_rdata_out;
    wire logic irq_out, rxd_pin_in, txd_pin_out, rx_bit_out, sck_pin_out, sck_oe_n_out;
    wire logic sck_level_out, nak_out, iteration_out, tx_sync_sel_out, peer_sck, sck_pin_in;
    wire ums_cfg_type cfg_out;
    int n_mismatch, comparisons, cyc;
    assign sck_pin_in = sck_oe_n_out ? peer_sck : sck_pin_out;
    ums_top ums_top_inst (.*);
    ums_peer ums_peer_inst (.ref_clk_in(ref_clk_in), .level_in(lvl), .run_in(sck_oe_n_out),
        .rxd_pin_out(rxd_pin_in), .sck_pin_out(peer_sck));
    always #5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        sample_tick_in <= (cyc[3:0] == 4'h0);
        sck_gen_in <= cyc[2];
        sck_hist <= {sck_hist[2:0], sck_pin_in};
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic ums_cfg_type exp_cfg(input logic [31:0] v);
        ums_cfg_type c;
        c = '0;
        c.stop_reserved = (v[13:12] == 2'h3) || (v[13:12] == 2'h1 && v[8]);
        c.stop_half_bits = c.stop_reserved ? 3'h2 : 3'h2 + {1'b0, v[13:12]};
        c.char_bits = v[17] ? 4'h9 : 4'h5 + {2'h0, v[7:6]};
        c.msb_first = v[16];
        c.samples_per_bit = v[19] ? 5'h08 : 5'h10;
        c.rx_filter_en = v[28];
        c.line_code_enable = v[29];
        c.start_edge_polarity = v[30];
        c.single_start_delimiter = v[31];
        c.parity_sel = v[11:9];
        c.sync_mode = v[8];
        exp_cfg = c;
    endfunction : exp_cfg
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk32
    task automatic chk1(input logic got, input logic exp, input string what);
        chk32({31'h0, got}, {31'h0, exp}, what);
    endtask : chk1
    task automatic cycles(input int k);
        repeat (k) @(posedge ref_clk_in);
        #1;
    endtask : cycles
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask : rd_reg
    task automatic pulse(input logic [3:0] sel, output logic got);
        @(posedge ref_clk_in);
        {thr_write_in, iteration_clear_in, char_good_in, parity_err_in} <= sel;
        @(posedge ref_clk_in);
        {thr_write_in, iteration_clear_in, char_good_in, parity_err_in} <= 4'h0;
        #1 got = nak_out;
    endtask : pulse
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    initial begin
        {ref_clk_in, resetn_in, reg_wr_in, reg_rd_in, tx_bit_in} = '0;
        {parity_err_in, char_good_in, iteration_clear_in, thr_write_in, thr_sync_in} = '0;
        {reg_addr_in, reg_wdata_in, irq_status_in, n_mismatch, comparisons} = '0;
        lvl = 1'b1;
        lfsr_q = 32'ha956943e;
        repeat (3) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        cycles(3);
        foreach (rst_ofs[i]) begin
            rd_reg(rst_ofs[i], d);
            chk32(d, 32'h0, "reset or write-only read");
        end
        m = '0;
        for (int i = 0; i < 24; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            d = (i == 0) ? 32'hffff_ffff : lfsr_q;
            wr_reg(`UMS_OFS_IRQ_SET, d);
            m = m | (d & `UMS_IRQ_VALID);
            rd_reg(`UMS_OFS_IRQ_VIEW, d);
            chk32(d, m, "mask after set");
            lfsr_q = lfsr_next(lfsr_q);
            d = (i == 1) ? 32'h0 : lfsr_q;
            wr_reg(`UMS_OFS_IRQ_CLR, d);
            m = m & ~d;
            rd_reg(`UMS_OFS_IRQ_VIEW, d);
            chk32(d, m, "mask after clear");
            @(posedge ref_clk_in);
            irq_status_in <= 32'h1 << lfsr_q[4:0];
            cycles(2);
            chk1(irq_out, |((32'h1 << lfsr_q[4:0]) & m), "interrupt out");
        end
        $display("mask test done");
        for (int i = 0; i < 16; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            d = {lfsr_q[31:14], i[1:0], lfsr_q[11:9], i[2], lfsr_q[7:4], 4'h0};
            wr_reg(`UMS_OFS_MODE, d);
            rd_reg(`UMS_OFS_MODE, m);
            chk32(m, d & `UMS_MODE_WMASK, "mode readback");
            cycles(2);
            chk32(32'(cfg_out), 32'(exp_cfg(d)), "decoded mode");
        end
        $display("mode test done");
        for (int i = 0; i < 8; i++) begin
            wr_reg(`UMS_OFS_MODE, {16'h0, i[2:1], 14'h0});
            @(posedge ref_clk_in);
            lvl <= i[0];
            tx_bit_in <= ~i[0];
            cycles(12);
            chk1(txd_pin_out, (i[2:1] == 2'h0) ? ~i[0] : (i[2:1] == 2'h2) | i[0], "txd");
            chk1(rx_bit_out, (i[2:1] == 2'h2) ? ~i[0] : (i[2:1] == 2'h3) | i[0], "rx");
        end
        for (int k = 0; k < 3; k++) begin
            wr_reg(`UMS_OFS_MODE, {13'h0, k != 2, 12'h0, (k == 1) ? 2'h3 : 2'h0, 4'h0});
            cycles(3);
            chk1(sck_oe_n_out, k != 0, "clock pin enable");
            // pin level returns three edges late once the sources have settled
            cycles(5);
            chk1(sck_level_out, sck_hist[3], "clock pin level");
        end
        $display("pin test done");
        wr_reg(`UMS_OFS_MODE, 32'h0220_0004);
        for (int i = 0; i < 3; i++) begin
            pulse(4'h1, n);
            chk1(n, i < 2, "limited nak");
            chk1(iteration_out, i == 2, "iteration flag");
        end
        pulse(4'h4, n);
        chk1(iteration_out, 1'b0, "iteration cleared");
        pulse(4'h2, n);
        pulse(4'h1, n);
        chk1(n, 1'b1, "nak after good char");
        wr_reg(`UMS_OFS_MODE, 32'h0010_0004);
        pulse(4'h1, n);
        chk1(n, 1'b0, "inhibited nak");
        wr_reg(`UMS_OFS_MODE, 32'h0000_0004);
        repeat (3) begin
            pulse(4'h1, n);
            chk1(n, 1'b1, "plain nak");
        end
        wr_reg(`UMS_OFS_MODE, 32'h0000_0000);
        pulse(4'h1, n);
        chk1(n, 1'b0, "nak outside card mode");
        $display("nak test done");
        wr_reg(`UMS_OFS_MODE, 32'h0040_0000);
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk_in);
            thr_sync_in <= i[0];
            pulse(4'h8, n);
            chk1(tx_sync_sel_out, i[0], "variable sync");
        end
        wr_reg(`UMS_OFS_MODE, 32'h0000_0100);
        @(posedge ref_clk_in);
        thr_sync_in <= 1'b0;
        pulse(4'h8, n);
        cycles(1);
        chk1(tx_sync_sel_out, 1'b1, "configured sync");
        $display("sync test done");
        // a four-cycle glitch meets one tick at most; a long low meets two
        wr_reg(`UMS_OFS_MODE, 32'h1000_0000);
        for (int k = 0; k < 120; k++) begin
            @(posedge ref_clk_in);
            lvl <= (k < 50 || k >= 54) && k < 70;
            #1;
            if (k < 88) begin
                chk1(rx_bit_out, 1'b1, "filtered glitch");
            end
        end
        chk1(rx_bit_out, 1'b0, "filtered low");
        $display("filter test done");
        final_report();
    end
endmodule : tb_ums_top
`default_nettype wire

// file: ums_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module ums_monitor (
    input wire logic                 ref_clk_in,
    input wire logic                 resetn_in,
    input wire logic                 reg_rd_in,
    input wire logic [31:0]          reg_rdata_out,
    input wire logic [31:0]          irq_status_in,
    input wire logic                 irq_out,
    input wire logic                 sck_gen_in,
    input wire logic                 sck_pin_out,
    input wire logic                 sck_oe_n_out,
    input wire logic                 parity_err_in,
    input wire logic                 iteration_clear_in,
    input wire logic                 nak_out,
    input wire logic                 iteration_out,
    input wire ums_pkg::ums_cfg_type cfg_out
);
    import ums_pkg::*;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data outside its cycle");
    a_irq_cause: assert property (irq_out |-> $past(|(irq_status_in & 32'h001f_3fff)))
        else $error("interrupt without enabled source");
    a_sck_drive: assert property (!sck_oe_n_out |-> sck_pin_out == $past(sck_gen_in))
        else $error("clock pin drive value wrong");
    a_nak_cause: assert property (nak_out |-> $past(parity_err_in))
        else $error("nak without parity error");
    a_iter_rise: assert property ($rose(iteration_out) |-> $past(parity_err_in))
        else $error("iteration flag without error");
    a_iter_hold: assert property (iteration_out && !iteration_clear_in |=> iteration_out)
        else $error("iteration flag dropped");
    a_iter_clear: assert property (iteration_clear_in && !parity_err_in |=> !iteration_out)
        else $error("iteration flag not cleared");
    a_stop_sync: assert property (cfg_out.sync_mode |-> cfg_out.stop_half_bits != 3'h3)
        else $error("half stop in sync mode");
    a_char_len: assert property (cfg_out.char_bits <= 4'h9)
        else $error("character length too long");
    a_ovs_codes: assert property (cfg_out.samples_per_bit inside {5'h00, 5'h08, 5'h10})
        else $error("bad oversampling");
endmodule : ums_monitor
bind ums_top ums_monitor ums_monitor_inst (.*);
`default_nettype wire

// file: ums_peer.sv
`timescale 1ns/1ns
`default_nettype none
module ums_peer (
    input  wire logic ref_clk_in,
    input  wire logic level_in,
    input  wire logic run_in,
    output logic      rxd_pin_out,
    output logic      sck_pin_out
);
    logic [3:0] div_ff = 4'h0;
    // line is asynchronous to the block, so move it off the edge;
    // a continuous copy also carries the level set at time zero
    assign #3 rxd_pin_out = level_in;
    always_ff @(posedge ref_clk_in) begin
        div_ff <= div_ff + 4'h1;
    end
    // external clock stands still unless the far side is clocking
    assign sck_pin_out = run_in & div_ff[3];
endmodule : ums_peer
`default_nettype wire

// file: ums_pkg.sv
`default_nettype none
package ums_pkg;

    typedef struct packed {
        logic       single_start_delimiter;
        logic       start_edge_polarity;
        logic       line_code_enable;
        logic       rx_filter_en;
        logic       rsv27;
        logic [2:0] max_iteration;
        logic       rsv23;
        logic       var_sync;
        logic       repeat_nak_suppress;
        logic       nak_inhibit;
        logic       oversample_8;
        logic       clock_pin_drive;
        logic       nine_bit_char;
        logic       bit_order_sel;
        logic [1:0] channel_test_sel;
        logic [1:0] stop_count_sel;
        logic [2:0] parity_sel;
        logic       sync_mode;
        logic [1:0] char_length_field;
        logic [1:0] clock_source_sel;
        logic [3:0] op_mode;
    } ums_mode_type;

    // decoded settings handed to the shifters and baud logic
    typedef struct packed {
        logic [2:0] stop_half_bits;
        logic       stop_reserved;
        logic [3:0] char_bits;
        logic       msb_first;
        logic [4:0] samples_per_bit;
        logic       rx_filter_en;
        logic       line_code_enable;
        logic       start_edge_polarity;
        logic       single_start_delimiter;
        logic [2:0] parity_sel;
        logic       sync_mode;
    } ums_cfg_type;

    typedef enum logic [2:0] {
        UMS_NAK_IDLE  = 3'b001,
        UMS_NAK_COUNT = 3'b010,
        UMS_NAK_LIMIT = 3'b100
    } ums_nak_state_type;

    typedef struct packed {
        ums_mode_type      mode;
        logic [31:0]       irq_mask;
        logic [31:0]       rd_data;
        ums_cfg_type       cfg;
        logic              txd;
        logic              rx_int;
        logic              sck_drive;
        logic              sck_out;
        logic [2:0]        sck_sync;
        logic              sck_level;
        ums_nak_state_type nak_state;
        logic [2:0]        nak_cnt;
        logic              nak;
        logic              iteration;
        logic              sync_sel;
        logic              irq;
    } ums_state_type;

    typedef struct packed {
        logic [2:0] sync;
        logic       stable;
        logic [2:0] window;
        logic       line;
    } ums_filt_state_type;

    // a pin level counts once the second and third stages agree
    function automatic logic ums_agree(input logic [2:0] sync, input logic prev);
        ums_agree = (sync[1] == sync[2]) ? sync[2] : prev;
    endfunction : ums_agree

endpackage : ums_pkg
`default_nettype wire

// file: ums_regs.svh
`ifndef UMS_REGS_SVH
`define UMS_REGS_SVH

// register byte offsets
`define UMS_OFS_MODE        8'h04
`define UMS_OFS_IRQ_SET     8'h08
`define UMS_OFS_IRQ_CLR     8'h0c
`define UMS_OFS_IRQ_VIEW    8'h10

// reset values and writable bits
`define UMS_MODE_RST        32'h0000_0000
`define UMS_MODE_WMASK      32'hf77f_ffff
`define UMS_IRQ_RST         32'h0000_0000
`define UMS_IRQ_VALID       32'h001f_3fff
`define UMS_RDATA_RST       32'h0000_0000

// mode field codes
`define UMS_OPMODE_ISO_T0   4'h4
`define UMS_CLKSRC_EXT      2'h3
`define UMS_CH_NORMAL       2'h0
`define UMS_CH_ECHO         2'h1
`define UMS_CH_LOCAL        2'h2
`define UMS_CH_REMOTE       2'h3
`define UMS_STOP_ONE        2'h0
`define UMS_STOP_ONE_HALF   2'h1
`define UMS_STOP_TWO        2'h2

// decoded counts
`define UMS_HALF_BITS_1     3'h2
`define UMS_HALF_BITS_1_5   3'h3
`define UMS_HALF_BITS_2     3'h4
`define UMS_CHAR_BITS_9     4'h9
`define UMS_CHAR_BITS_BASE  4'h5
`define UMS_OVS_16          5'h10
`define UMS_OVS_8           5'h08
`define UMS_NAK_CNT_RST     3'h0
`define UMS_SYNC_IDLE       3'h7

`endif

// file: ums_rx_filter.sv
`timescale 1ns/1ns
`default_nettype none
`include "ums_regs.svh"
module ums_rx_filter (
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    input  wire logic pin_in,
    input  wire logic tick_in,
    input  wire logic filter_en_in,
    output logic      line_out
);
    import ums_pkg::*;

    ums_filt_state_type st_ff;
    ums_filt_state_type nxt_st;

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.sync   = {st_ff.sync[1:0], pin_in};
        nxt_st.stable = ums_agree(st_ff.sync, st_ff.stable);
        if (tick_in) begin
            nxt_st.window = {st_ff.window[1:0], st_ff.stable};
        end
        if (filter_en_in) begin
            // two of three samples taken a sixteenth of a bit apart
            nxt_st.line = (st_ff.window[0] & st_ff.window[1]) | (st_ff.window[1] & st_ff.window[2])
                        | (st_ff.window[0] & st_ff.window[2]);
        end else begin
            nxt_st.line = st_ff.stable;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= '{sync: `UMS_SYNC_IDLE, stable: 1'b1, window: `UMS_SYNC_IDLE, line: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign line_out = st_ff.line;

endmodule : ums_rx_filter
`default_nettype wire

// file: ums_top.sv
// Contract
// - stop field picks 1, 1.5, 2 stop bits; sync mode forbids 1.5 and top code
// - channel code 00 normal; 01 echoes the receive line onto the serial output
// - channel code 10 feeds transmitter output into the receiver
// - channel code 11 ties serial input pin straight to serial output pin; here via the synchroniser, receive filter and output register
// - bit order: lsb first when clear, msb first when set, both directions
// - nine-bit setting forces 9-bit characters, else length field governs
// - clock pin driven only with drive enabled and internal clock source
// - oversampling 16 per bit when clear, 8 when set
// - nak inhibit set means no nak ever on the card line
// - suppression off: nak on every parity error unless inhibited
// - suppression on: nak per error until limit reached, then none and flag
// - iteration limit field bounds repetitions in card protocol zero
// - variable sync takes sync choice from each holding register write
// - receive filter: two-of-three majority at one sixteenth bit
// - line code enable turns encoder and decoder on together
// - start polarity: low-to-high when clear, high-to-low when set
// - delimiter selector: sync pattern when clear, single start bit when set
// - nineteen sources at bits 0..13 and 16..20, others unused
// - enable register: ones set mask bits, zeros leave them
// - disable register: ones clear mask bits, zeros leave them
// - mask view reads one per enabled source
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "ums_regs.svh"
module ums_top (
    input  wire logic           ref_clk_in,
    input  wire logic           resetn_in,
    input  wire logic [7:0]     reg_addr_in,
    input  wire logic [31:0]    reg_wdata_in,
    input  wire logic           reg_wr_in,
    input  wire logic           reg_rd_in,
    output logic [31:0]         reg_rdata_out,
    input  wire logic [31:0]    irq_status_in,
    output logic                irq_out,
    input  wire logic           rxd_pin_in,
    output logic                txd_pin_out,
    input  wire logic           tx_bit_in,
    output logic                rx_bit_out,
    input  wire logic           sample_tick_in,
    input  wire logic           sck_gen_in,
    input  wire logic           sck_pin_in,
    output logic                sck_pin_out,
    output logic                sck_oe_n_out,
    output logic                sck_level_out,
    input  wire logic           parity_err_in,
    input  wire logic           char_good_in,
    input  wire logic           iteration_clear_in,
    output logic                nak_out,
    output logic                iteration_out,
    input  wire logic           thr_write_in,
    input  wire logic           thr_sync_in,
    output logic                tx_sync_sel_out,
    output ums_pkg::ums_cfg_type cfg_out
);
    import ums_pkg::*;

    logic [1:0]    rst_sync_ff;
    logic          rst_n;
    logic          rx_line;
    ums_state_type st_ff;
    ums_state_type nxt_st;

    // reset enters asynchronously, leaves synchronously
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    ums_rx_filter u_rx_filter (
        .ref_clk_in   (ref_clk_in),
        .rst_n_in     (rst_n),
        .pin_in       (rxd_pin_in),
        .tick_in      (sample_tick_in),
        .filter_en_in (st_ff.mode.rx_filter_en),
        .line_out     (rx_line)
    );

    function automatic ums_cfg_type decode_mode(input ums_mode_type m);
        ums_cfg_type c;
        c = '0;
        c.stop_reserved = 1'b0;
        case (m.stop_count_sel)
            `UMS_STOP_ONE: begin
                c.stop_half_bits = `UMS_HALF_BITS_1;
            end
            `UMS_STOP_ONE_HALF: begin
                // 1.5 stop bits exist only without a clock line
                c.stop_half_bits = m.sync_mode ? `UMS_HALF_BITS_1 : `UMS_HALF_BITS_1_5;
                c.stop_reserved  = m.sync_mode;
            end
            `UMS_STOP_TWO: begin
                c.stop_half_bits = `UMS_HALF_BITS_2;
            end
            default: begin
                c.stop_half_bits = `UMS_HALF_BITS_1;
                c.stop_reserved  = 1'b1;
            end
        endcase
        c.char_bits = m.nine_bit_char ? `UMS_CHAR_BITS_9
                    : (`UMS_CHAR_BITS_BASE + {2'h0, m.char_length_field});
        c.msb_first              = m.bit_order_sel;
        c.samples_per_bit        = m.oversample_8 ? `UMS_OVS_8 : `UMS_OVS_16;
        c.rx_filter_en           = m.rx_filter_en;
        c.line_code_enable       = m.line_code_enable;
        c.start_edge_polarity    = m.start_edge_polarity;
        c.single_start_delimiter = m.single_start_delimiter;
        c.parity_sel             = m.parity_sel;
        c.sync_mode              = m.sync_mode;
        return c;
    endfunction : decode_mode

    always_comb begin
        logic [31:0] wbits;
        logic        iso_t0;
        logic        nak_now;
        logic        iter_set;
        wbits    = reg_wdata_in & `UMS_IRQ_VALID;
        iso_t0   = (st_ff.mode.op_mode == `UMS_OPMODE_ISO_T0);
        nak_now  = 1'b0;
        iter_set = 1'b0;
        nxt_st   = st_ff;

        // register writes
        if (reg_wr_in) begin
            case (reg_addr_in)
                `UMS_OFS_MODE: begin
                    nxt_st.mode = ums_mode_type'(reg_wdata_in & `UMS_MODE_WMASK);
                end
                `UMS_OFS_IRQ_SET: begin
                    nxt_st.irq_mask = st_ff.irq_mask | wbits;
                end
                `UMS_OFS_IRQ_CLR: begin
                    nxt_st.irq_mask = st_ff.irq_mask & ~wbits;
                end
                default: begin
                end
            endcase
        end

        // read data valid only in the cycle after the strobe
        nxt_st.rd_data = `UMS_RDATA_RST;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `UMS_OFS_MODE: begin
                    nxt_st.rd_data = st_ff.mode;
                end
                `UMS_OFS_IRQ_VIEW: begin
                    nxt_st.rd_data = st_ff.irq_mask;
                end
                default: begin
                    nxt_st.rd_data = `UMS_RDATA_RST;
                end
            endcase
        end

        nxt_st.cfg = decode_mode(st_ff.mode);

        // channel test routing; unused side idles high
        case (st_ff.mode.channel_test_sel)
            `UMS_CH_NORMAL: begin
                nxt_st.txd    = tx_bit_in;
                nxt_st.rx_int = rx_line;
            end
            `UMS_CH_ECHO: begin
                nxt_st.txd    = rx_line;
                nxt_st.rx_int = rx_line;
            end
            `UMS_CH_LOCAL: begin
                nxt_st.txd    = 1'b1;
                nxt_st.rx_int = tx_bit_in;
            end
            default: begin
                // receiver and transmitter play no part here
                nxt_st.txd    = rx_line;
                nxt_st.rx_int = 1'b1;
            end
        endcase

        nxt_st.sck_drive = st_ff.mode.clock_pin_drive
                         && (st_ff.mode.clock_source_sel != `UMS_CLKSRC_EXT);
        nxt_st.sck_out   = sck_gen_in;
        nxt_st.sck_sync  = {st_ff.sck_sync[1:0], sck_pin_in};
        nxt_st.sck_level = ums_agree(st_ff.sck_sync, st_ff.sck_level);

        // card-line nak decision, one per received parity error
        case (st_ff.nak_state)
            UMS_NAK_IDLE: begin
                if (parity_err_in && iso_t0) begin
                    if (!st_ff.mode.repeat_nak_suppress) begin
                        nak_now = !st_ff.mode.nak_inhibit;
                    end else if (st_ff.mode.max_iteration == `UMS_NAK_CNT_RST) begin
                        iter_set         = 1'b1;
                        nxt_st.nak_state = UMS_NAK_LIMIT;
                    end else begin
                        nak_now          = !st_ff.mode.nak_inhibit;
                        nxt_st.nak_cnt   = 3'h1;
                        nxt_st.nak_state = UMS_NAK_COUNT;
                    end
                end
            end
            UMS_NAK_COUNT: begin
                if (char_good_in || !st_ff.mode.repeat_nak_suppress) begin
                    nxt_st.nak_cnt   = `UMS_NAK_CNT_RST;
                    nxt_st.nak_state = UMS_NAK_IDLE;
                end else if (parity_err_in) begin
                    if (st_ff.nak_cnt >= st_ff.mode.max_iteration) begin
                        iter_set         = 1'b1;
                        nxt_st.nak_state = UMS_NAK_LIMIT;
                    end else begin
                        nak_now        = !st_ff.mode.nak_inhibit;
                        nxt_st.nak_cnt = st_ff.nak_cnt + 3'h1;
                    end
                end
            end
            UMS_NAK_LIMIT: begin
                // no more naks until a good character or suppression turned off restarts the run
                if (char_good_in || !st_ff.mode.repeat_nak_suppress) begin
                    nxt_st.nak_cnt   = `UMS_NAK_CNT_RST;
                    nxt_st.nak_state = UMS_NAK_IDLE;
                end
            end
            default: begin
                nxt_st.nak_cnt   = `UMS_NAK_CNT_RST;
                nxt_st.nak_state = UMS_NAK_IDLE;
            end
        endcase
        nxt_st.nak = nak_now;
        // a limit hit in the clear cycle still shows
        nxt_st.iteration = iter_set | (st_ff.iteration & ~iteration_clear_in);

        if (!st_ff.mode.var_sync) begin
            nxt_st.sync_sel = st_ff.mode.sync_mode;
        end else if (thr_write_in) begin
            nxt_st.sync_sel = thr_sync_in;
        end

        nxt_st.irq = |(irq_status_in & st_ff.irq_mask & `UMS_IRQ_VALID);
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_ff           <= '0;
            st_ff.mode      <= ums_mode_type'(`UMS_MODE_RST);
            st_ff.irq_mask  <= `UMS_IRQ_RST;
            st_ff.txd       <= 1'b1;
            st_ff.rx_int    <= 1'b1;
            st_ff.sck_sync  <= `UMS_SYNC_IDLE;
            st_ff.sck_level <= 1'b1;
            st_ff.nak_state <= UMS_NAK_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata_out   = st_ff.rd_data;
    assign irq_out         = st_ff.irq;
    assign txd_pin_out     = st_ff.txd;
    assign rx_bit_out      = st_ff.rx_int;
    assign sck_pin_out     = st_ff.sck_out;
    assign sck_oe_n_out    = ~st_ff.sck_drive;
    assign sck_level_out   = st_ff.sck_level;
    assign nak_out         = st_ff.nak;
    assign iteration_out   = st_ff.iteration;
    assign tx_sync_sel_out = st_ff.sync_sel;
    assign cfg_out         = st_ff.cfg;

endmodule : ums_top
`default_nettype wire
